/* aacc_ctrl.sv */
// Auxiliary converter control, status and APB register file
`default_nettype none
// Functional notes
// - Length code gives 20/22/26/34 converter cycles
// - Source code routes selected input to converter
// - Any config register write starts a conversion
// - Result bits 11:4 read at high register
// - Result bits 3:0 in status bits 7:4
// - Done flag low while converting, high valid
// - Status bits 2:0 echo converted source code
// - Gate bit stops or runs converter clock
// - Soft reset on rising edge only
// - Divider code sets converter clock ratio
// - Ratios 256 down to 2, halving
module aacc_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [aacc_pkg::RESULT_W-1:0] conversion_result, // Converter output pins
  output logic [aacc_pkg::SRC_W-1:0] source_select, // Input mux select
  output logic converter_clock, // Converter clock enable pulse
  output logic converter_soft_reset, // Converter reset pulse
  output logic conversion_busy // Conversion in progress
);
  aacc_pkg::aacc_config_s config_ff, nxt_config;
  aacc_pkg::aacc_control_s control_ff, nxt_control;
  aacc_pkg::aacc_state_e state_ff, nxt_state;
  logic srst_prev_ff, nxt_srst_prev;
  logic srst_pulse_ff, nxt_srst_pulse;
  logic [aacc_pkg::CYC_W-1:0] cyc_ff, nxt_cyc;
  logic [aacc_pkg::CYC_W-1:0] len_m1_ff, nxt_len_m1;
  logic [aacc_pkg::SRC_W-1:0] src_latched_ff, nxt_src_latched;
  logic [aacc_pkg::SRC_W-1:0] echo_ff, nxt_echo;
  logic [aacc_pkg::RESULT_W-1:0] result_ff, nxt_result;
  logic done_ff, nxt_done;
  logic [aacc_pkg::RESULT_W-1:0] res_sync1_ff, res_sync2_ff;
  logic [ADDR_W-3:0] word_idx;
  aacc_pkg::aacc_config_s wr_cfg;
  logic access, wr_en, start, tick, hit_cfg, hit_hi, hit_lo, hit_ctl, mapped, last_cycle;

  // APB decode; zero wait states
  assign word_idx = paddr[ADDR_W-1:2];
  assign hit_cfg = (word_idx == aacc_pkg::IDX_CONFIG_START);
  assign hit_hi = (word_idx == aacc_pkg::IDX_RESULT_HIGH);
  assign hit_lo = (word_idx == aacc_pkg::IDX_RESULT_LOW_STATUS);
  assign hit_ctl = (word_idx == aacc_pkg::IDX_CONTROL);
  assign mapped = hit_cfg || hit_hi || hit_lo || hit_ctl;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_en = access && pwrite && mapped;
  assign start = wr_en && hit_cfg;
  assign wr_cfg = pwdata[7:0];

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_cfg) begin
      prdata[7:0] = config_ff;
    end else if (hit_hi) begin
      prdata[7:0] = result_ff[11:4];
    end else if (hit_lo) begin
      prdata[7:0] = {result_ff[3:0], done_ff, echo_ff};
    end else if (hit_ctl) begin
      prdata[7:0] = control_ff;
    end
  end

  // Register writes and soft reset edge detect
  always_comb begin
    nxt_config = config_ff;
    nxt_control = control_ff;
    if (start) begin
      nxt_config = wr_cfg;
    end
    if (wr_en && hit_ctl) begin
      nxt_control = pwdata[7:0];
    end
    nxt_srst_prev = control_ff.converter_soft_reset;
    nxt_srst_pulse = control_ff.converter_soft_reset && !srst_prev_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_ff <= aacc_pkg::CONFIG_RESET;
      control_ff <= aacc_pkg::CONTROL_RESET;
      srst_prev_ff <= 1'b0;
      srst_pulse_ff <= 1'b0;
    end else begin
      config_ff <= nxt_config;
      control_ff <= nxt_control;
      srst_prev_ff <= nxt_srst_prev;
      srst_pulse_ff <= nxt_srst_pulse;
    end
  end

  assign source_select = config_ff.source_select;
  assign converter_soft_reset = srst_pulse_ff;
  assign converter_clock = tick;
  assign conversion_busy = (state_ff == aacc_pkg::AACC_CONV);

  aacc_clk_div #(
    .DIV_W(aacc_pkg::DIV_W),
    .CNT_W(aacc_pkg::DIV_CNT_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(control_ff.converter_clock_gate),
    .restart(srst_pulse_ff),
    .div_sel(control_ff.converter_clock_divider),
    .tick(tick)
  );

  // Converter output sampled across from the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_sync1_ff <= '0;
      res_sync2_ff <= '0;
    end else begin
      res_sync1_ff <= conversion_result;
      res_sync2_ff <= res_sync1_ff;
    end
  end

  assign last_cycle = (state_ff == aacc_pkg::AACC_CONV) && tick && (cyc_ff == len_m1_ff);

  // Conversion sequencer; a new start abandons any running conversion
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_len_m1 = len_m1_ff;
    nxt_src_latched = src_latched_ff;
    nxt_echo = echo_ff;
    nxt_result = result_ff;
    nxt_done = done_ff;
    if (start) begin
      nxt_state = aacc_pkg::AACC_CONV;
      nxt_cyc = '0;
      nxt_len_m1 = aacc_pkg::conv_len_m1(wr_cfg.conversion_length_sel);
      nxt_src_latched = wr_cfg.source_select;
      nxt_done = 1'b0;
    end else if (srst_pulse_ff) begin
      nxt_state = aacc_pkg::AACC_IDLE;
      nxt_cyc = '0;
      nxt_done = 1'b1;
    end else begin
      case (state_ff)
        aacc_pkg::AACC_IDLE: begin
          nxt_cyc = '0;
        end
        aacc_pkg::AACC_CONV: begin
          if (last_cycle) begin
            nxt_state = aacc_pkg::AACC_IDLE;
            nxt_result = res_sync2_ff;
            nxt_echo = src_latched_ff;
            nxt_done = 1'b1;
          end else if (tick) begin
            nxt_cyc = cyc_ff + 6'h01;
          end
        end
        default: begin
          nxt_state = aacc_pkg::AACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= aacc_pkg::AACC_IDLE;
      cyc_ff <= '0;
      len_m1_ff <= '0;
      src_latched_ff <= '0;
      echo_ff <= '0;
      result_ff <= '0;
      done_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      len_m1_ff <= nxt_len_m1;
      src_latched_ff <= nxt_src_latched;
      echo_ff <= nxt_echo;
      result_ff <= nxt_result;
      done_ff <= nxt_done;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    psel && penable && pwrite && hit_cfg;
  endsequence

  sequence s_finish;
    last_cycle && !start && !srst_pulse_ff;
  endsequence

  property p_start_clears;
    s_start |=> !done_ff && conversion_busy && cyc_ff == 6'h00;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("Start did not clear flag");

  property p_finish;
    s_finish |=> done_ff && !conversion_busy && result_ff == $past(res_sync2_ff);
  endproperty
  a_finish: assert property (p_finish) else $error("Finish did not capture result");

  property p_length;
    $rose(done_ff) && !$past(srst_pulse_ff) |-> $past(cyc_ff) == $past(len_m1_ff);
  endproperty
  a_length: assert property (p_length) else $error("Conversion length wrong");

  property p_len_table;
    s_start |=> ($past(pwdata[7:6]) == 2'h0 && len_m1_ff == 6'h13) ||
      ($past(pwdata[7:6]) == 2'h1 && len_m1_ff == 6'h15) ||
      ($past(pwdata[7:6]) == 2'h2 && len_m1_ff == 6'h19) ||
      ($past(pwdata[7:6]) == 2'h3 && len_m1_ff == 6'h21);
  endproperty
  a_len_table: assert property (p_len_table) else $error("Length code gave wrong count");

  property p_echo;
    $rose(done_ff) && !$past(srst_pulse_ff) |-> echo_ff == source_select;
  endproperty
  a_echo: assert property (p_echo) else $error("Source echo mismatch");

  property p_src;
    s_start |=> source_select == $past(pwdata[2:0]);
  endproperty
  a_src: assert property (p_src) else $error("Source select not routed");

  property p_high_read;
    psel && !pwrite && hit_hi |-> prdata == {24'h000000, result_ff[11:4]};
  endproperty
  a_high_read: assert property (p_high_read) else $error("High result read wrong");

  property p_low_read;
    psel && !pwrite && hit_lo |-> prdata[7:3] == {result_ff[3:0], done_ff};
  endproperty
  a_low_read: assert property (p_low_read) else $error("Low result read wrong");

  property p_gate;
    !control_ff.converter_clock_gate |-> !converter_clock;
  endproperty
  a_gate: assert property (p_gate) else $error("Converter clock ran while gated");

  property p_srst_edge;
    converter_soft_reset |=> !converter_soft_reset;
  endproperty
  a_srst_edge: assert property (p_srst_edge) else $error("Soft reset repeated on level");

  property p_busy_done;
    conversion_busy |-> !done_ff;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("Done flag high while busy");

  property p_hold;
    !last_cycle |=> $stable(result_ff) && $stable(echo_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("Result changed outside completion");

  property p_ro_write;
    access && pwrite && (hit_hi || hit_lo) |=> $stable(config_ff) && $stable(control_ff);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Read-only write changed a register");

  property p_cfg_write;
    s_start |=> config_ff == $past(pwdata[7:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("Config write did not land");

  property p_ctl_write;
    access && pwrite && hit_ctl |=> control_ff == $past(pwdata[7:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("Control write did not land");

  sequence s_srst_req;
    $rose(control_ff.converter_soft_reset);
  endsequence

  property p_srst_rise;
    s_srst_req |=> converter_soft_reset;
  endproperty
  a_srst_rise: assert property (p_srst_rise) else $error("Rising reset bit gave no pulse");

  property p_srst_level;
    !$rose(control_ff.converter_soft_reset) |=> !converter_soft_reset;
  endproperty
  a_srst_level: assert property (p_srst_level) else $error("Reset pulse without rising bit");

  property p_srst_abort;
    converter_soft_reset && !start |=> !conversion_busy && done_ff;
  endproperty
  a_srst_abort: assert property (p_srst_abort) else $error("Soft reset did not abort");

  property p_stall;
    conversion_busy && !converter_clock && !start && !converter_soft_reset |=> $stable(cyc_ff);
  endproperty
  a_stall: assert property (p_stall) else $error("Cycle count moved without a tick");
endmodule
`default_nettype wire

/* aacc_pkg.sv */
// Shared constants and types for the auxiliary converter control block
`default_nettype none
package aacc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CONFIG_START = 10'h077;
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h078;
  localparam logic [9:0] IDX_RESULT_LOW_STATUS = 10'h079;
  localparam logic [9:0] IDX_CONTROL = 10'h07a;

  localparam int RESULT_W = 12;
  localparam int SRC_W = 3;
  localparam int LEN_W = 2;
  localparam int DIV_W = 3;
  localparam int CYC_W = 6;
  localparam int DIV_CNT_W = 8;

  // Conversion lengths in converter clock cycles
  localparam logic [CYC_W-1:0] CONV_LEN_00 = 6'h14;
  localparam logic [CYC_W-1:0] CONV_LEN_01 = 6'h16;
  localparam logic [CYC_W-1:0] CONV_LEN_10 = 6'h1a;
  localparam logic [CYC_W-1:0] CONV_LEN_11 = 6'h22;

  // Divider ratio 256 for code zero, halving per code step
  localparam logic [DIV_CNT_W:0] DIV_MAX_RATIO = 9'h100;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef struct packed {
    logic [LEN_W-1:0] conversion_length_sel;
    logic [2:0] unused;
    logic [SRC_W-1:0] source_select;
  } aacc_config_s;

  typedef struct packed {
    logic converter_clock_gate;
    logic converter_soft_reset;
    logic [2:0] unused;
    logic [DIV_W-1:0] converter_clock_divider;
  } aacc_control_s;

  typedef enum logic [1:0] {
    AACC_IDLE = 2'b00,
    AACC_CONV = 2'b01
  } aacc_state_e;

  function automatic logic [CYC_W-1:0] conv_len_m1(input logic [LEN_W-1:0] sel);
    logic [CYC_W-1:0] len;
    case (sel)
      2'h0: len = CONV_LEN_00;
      2'h1: len = CONV_LEN_01;
      2'h2: len = CONV_LEN_10;
      default: len = CONV_LEN_11;
    endcase
    return len - 6'h01;
  endfunction
endpackage
`default_nettype wire

/* aacc_clk_div.sv */
// Converter clock divider producing a one-cycle enable pulse
`default_nettype none
module aacc_clk_div #(
  parameter int DIV_W = 3,
  parameter int CNT_W = 8
) (
  input wire logic pclk, // Main clock
  input wire logic presetn, // Async reset, active low
  input wire logic enable, // Clock gate
  input wire logic restart, // Restart the count
  input wire logic [DIV_W-1:0] div_sel, // Ratio code
  output logic tick // Converter clock enable pulse
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W:0] ratio;
  logic [CNT_W-1:0] ratio_m1;

  assign ratio = aacc_pkg::DIV_MAX_RATIO >> div_sel;
  assign ratio_m1 = CNT_W'(ratio - (CNT_W+1)'(1));
  assign tick = enable && (cnt_ff >= ratio_m1);

  always_comb begin
    if (restart || !enable || tick) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_div_ratio;
    tick |=> !tick;
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("Divider ticked twice in a row");

  property p_div_code;
    (div_sel == 3'h7 && enable && !restart && tick && $stable(div_sel)) |=>
      ##1 (tick || !enable || div_sel != 3'h7 || $past(restart) || !$past(enable));
  endproperty
  a_div_code: assert property (p_div_code) else $error("Ratio two divider not ticking");
endmodule
`default_nettype wire

/* aacc_ctrl_tb.sv */
// Self-checking testbench for the auxiliary converter control block
`default_nettype none
module aacc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_CFG = {aacc_pkg::IDX_CONFIG_START, 2'b00};
  localparam logic [11:0] A_HI = {aacc_pkg::IDX_RESULT_HIGH, 2'b00};
  localparam logic [11:0] A_STS = {aacc_pkg::IDX_RESULT_LOW_STATUS, 2'b00};
  localparam logic [11:0] A_CTL = {aacc_pkg::IDX_CONTROL, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, conversion_result, last_res;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] source_select;
  logic converter_clock, converter_soft_reset, conversion_busy;
  int num_errors, check_count, tick_cnt, rst_cnt, snap;
  int lens[4] = '{20, 22, 26, 34};

  aacc_ctrl aacc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conversion_result(conversion_result), .source_select(source_select),
    .converter_clock(converter_clock), .converter_soft_reset(converter_soft_reset),
    .conversion_busy(conversion_busy));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Running counts of converter ticks and reset pulses
  always @(posedge pclk) begin
    if (converter_clock === 1'b1) tick_cnt <= tick_cnt + 1;
    if (converter_soft_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  task summarize;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
  endtask

  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (converter_clock !== 1'b1 && n < 600);
    if (n >= 600) begin
      num_errors++;
      summarize();
    end
  endtask

  task wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (conversion_busy !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      summarize();
    end
  endtask

  task t_reset;
    apb(1'b0, A_CFG, 8'h00);
    check("config", 32'h0, rd);
    apb(1'b0, A_CTL, 8'h00);
    check("control", 32'h0, rd);
    apb(1'b0, A_STS, 8'h00);
    check("status", 32'h08, rd);
    apb(1'b0, 12'h000, 8'h00);
    check("unmapped read err", 32'h1, {31'h0, err});
    apb(1'b1, 12'hffc, 8'hff);
    check("unmapped write err", 32'h1, {31'h0, err});
  endtask

  task t_div;
    int n;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, A_CTL, 8'h80 | 8'(c));
      wait_tick(n);
      wait_tick(n);
      check("tick period", 32'(256 >> c), 32'(n));
    end
  endtask

  task t_conv;
    logic [11:0] r;
    apb(1'b1, A_CTL, 8'h87);
    for (int i = 0; i < 8; i++) begin
      r = 12'h5a3 + 12'(i) * 12'h111;
      @(posedge pclk);
      conversion_result <= r;
      // Unused bits set to show any value starts
      apb(1'b1, A_CFG, {2'(i), 3'b101, 3'(i)});
      #1;
      snap = tick_cnt;
      check("busy", 32'h1, {31'h0, conversion_busy});
      check("source_select", 32'(i), {29'h0, source_select});
      apb(1'b0, A_STS, 8'h00);
      check("done while running", 32'h0, {31'h0, rd[3]});
      wait_idle();
      check("ticks", 32'(lens[i % 4]), 32'(tick_cnt - snap));
      apb(1'b0, A_HI, 8'h00);
      check("result high", {24'h0, r[11:4]}, rd);
      apb(1'b0, A_STS, 8'h00);
      check("status", {24'h0, r[3:0], 1'b1, 3'(i)}, rd);
      last_res = r;
    end
  endtask

  task t_gate;
    apb(1'b1, A_CTL, 8'h07);
    #1;
    snap = tick_cnt;
    apb(1'b1, A_CFG, 8'h02);
    repeat (300) @(posedge pclk);
    #1;
    check("gated ticks", 32'h0, 32'(tick_cnt - snap));
    check("busy gated", 32'h1, {31'h0, conversion_busy});
    apb(1'b1, A_CTL, 8'h87);
    wait_idle();
    apb(1'b0, A_STS, 8'h00);
    check("status after gate", 32'ha, {28'h0, rd[3:0]});
    last_res = conversion_result;
  endtask

  task t_srst;
    apb(1'b1, A_CTL, 8'h80);
    @(posedge pclk);
    conversion_result <= ~last_res;
    apb(1'b1, A_CFG, 8'hc1);
    snap = rst_cnt;
    apb(1'b1, A_CTL, 8'hc0);
    repeat (4) @(posedge pclk);
    #1;
    check("reset pulses", 32'h1, 32'(rst_cnt - snap));
    check("busy after reset", 32'h0, {31'h0, conversion_busy});
    apb(1'b0, A_HI, 8'h00);
    check("result kept", {24'h0, last_res[11:4]}, rd);
    // Writes to the read-only result register are ignored without error
    apb(1'b1, A_HI, 8'h55);
    check("read-only write err", 32'h0, {31'h0, err});
    apb(1'b0, A_HI, 8'h00);
    check("result after write", {24'h0, last_res[11:4]}, rd);
    apb(1'b0, A_STS, 8'h00);
    check("done after reset", 32'h1, {31'h0, rd[3]});
    apb(1'b1, A_CTL, 8'hc0);
    repeat (4) @(posedge pclk);
    #1;
    check("steady level pulses", 32'h1, 32'(rst_cnt - snap));
    apb(1'b1, A_CTL, 8'h87);
    apb(1'b1, A_CTL, 8'hc7);
    repeat (4) @(posedge pclk);
    #1;
    check("second reset pulses", 32'h2, 32'(rst_cnt - snap));
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    conversion_result = 12'h000;
    last_res = 12'h000;
    tick_cnt = 0;
    rst_cnt = 0;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_div();
    t_conv();
    t_gate();
    t_srst();
    summarize();
  end
endmodule
`default_nettype wire
